// file: rtl/uar_regs.svh
// constants for the asynchronous receive recovery block
`ifndef UAR_REGS_SVH
`define UAR_REGS_SVH

`define UAR_CLK_PERIOD_NS  50
`define UAR_SPB_NORMAL     5'h10
`define UAR_SPB_DOUBLE     5'h08
`define UAR_SF_NORMAL      5'h08
`define UAR_SF_DOUBLE      5'h04
`define UAR_DATA_BITS_MIN  4'h5
`define UAR_DATA_BITS_MAX  4'h9
`define UAR_FIFO_DEPTH     16
`define UAR_WORD_W         11
`define UAR_FE_POS         10
`define UAR_PAR_POS        9
`define UAR_DIV_W          12

`endif

// file: rtl/uar_pkg.sv
// types of the asynchronous receive recovery block
package uar_pkg;
	typedef enum logic [1:0] {
		UAR_IDLE  = 2'b00,
		UAR_START = 2'b01,
		UAR_DATA  = 2'b10,
		UAR_PUSH  = 2'b11
	} uar_state_t;
endpackage : uar_pkg

// file: rtl/uar_fifo.sv
// receive word fifo with registered read data
`timescale 1ns/100ps
module uar_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign o_in_ready = (count_q != (AW+1)'(DEPTH));
	assign push       = i_in_valid && o_in_ready;
	// refill the output stage whenever it is empty or being taken
	assign pop        = (count_q != '0) && (!o_out_valid || i_out_ready);

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wptr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_out_valid <= 1'b0;
			o_out_data  <= '0;
		end else if (pop) begin
			o_out_valid <= 1'b1;
			o_out_data  <= mem_q[rptr_q];
		end else if (i_out_ready) begin
			o_out_valid <= 1'b0;
		end
	end
endmodule : uar_fifo

// file: rtl/uar_rx.sv
// asynchronous receive clock and data recovery with frame fifo
`timescale 1ns/100ps
`include "uar_regs.svh"
module uar_rx
	import uar_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_serial_rx_line,
	input  wire logic                   i_double_speed_select,
	input  wire logic [`UAR_DIV_W-1:0]  i_baud_divisor,
	input  wire logic [3:0]             i_data_bits,
	input  wire logic                   i_parity_en,
	input  wire logic                   i_rx_ready,
	output logic                        o_rx_valid,
	output logic [8:0]                  o_rx_data,
	output logic                        o_rx_parity,
	output logic                        o_frame_error_flag
);
	// ********************************
	// helpers
	// ********************************
	function automatic logic vote3(input logic [2:0] s);
		vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : vote3
	function automatic logic [4:0] spb(input logic dbl);
		spb = dbl ? `UAR_SPB_DOUBLE : `UAR_SPB_NORMAL;
	endfunction : spb
	function automatic logic [4:0] first_vote(input logic dbl);
		first_vote = dbl ? `UAR_SF_DOUBLE : `UAR_SF_NORMAL;
	endfunction : first_vote
	function automatic logic [3:0] clamp_bits(input logic [3:0] n);
		clamp_bits = (n < `UAR_DATA_BITS_MIN) ? `UAR_DATA_BITS_MIN
			: (n > `UAR_DATA_BITS_MAX) ? `UAR_DATA_BITS_MAX : n;
	endfunction : clamp_bits

	// ********************************
	// line synchroniser
	// ********************************
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic line_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
			line_q  <= 1'b1;
		end else begin
			sync1_q <= i_serial_rx_line;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q) begin
				line_q <= sync3_q;
			end
		end
	end

	// ********************************
	// sample tick from baud divisor
	// ********************************
	logic [`UAR_DIV_W-1:0] div_q;
	logic                  tick_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == '0) begin
			div_q  <= i_baud_divisor;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q - 1'b1;
			tick_q <= 1'b0;
		end
	end

	// ********************************
	// recovery state machine
	// ********************************
	uar_state_t                 state_q;
	logic       [4:0]           samp_q;
	logic       [3:0]           bit_q;
	logic       [2:0]           votes_q;
	logic                       prev_hi_q;
	logic                       dbl_q;
	logic       [3:0]           nbits_q;
	logic                       par_en_q;
	logic       [8:0]           data_q;
	logic                       par_q;
	logic                       fe_q;
	logic       [4:0]           sf;
	logic       [2:0]           vset;
	logic                       in_window;
	logic                       vote_end;
	logic                       bit_val;
	logic       [3:0]           last_bit;
	logic                       fifo_ready;
	logic [`UAR_WORD_W-1:0]     word;
	assign sf        = first_vote(dbl_q);
	assign in_window = (samp_q >= sf) && (samp_q <= sf + 5'h02);
	assign vote_end  = tick_q && (samp_q == sf + 5'h02);
	assign vset      = {votes_q[1:0], line_q};
	assign bit_val   = vote3(vset);
	// index of the first stop bit; later stop bits are never sampled
	assign last_bit  = nbits_q + {3'h0, par_en_q} + 4'h1;
	assign word      = {fe_q, par_q, data_q};
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q   <= UAR_IDLE;
			samp_q    <= 5'h00;
			bit_q     <= 4'h0;
			votes_q   <= 3'h7;
			prev_hi_q <= 1'b0;
			dbl_q     <= 1'b0;
			nbits_q   <= `UAR_DATA_BITS_MAX;
			par_en_q  <= 1'b0;
		end else begin
			case (state_q)
			UAR_IDLE: begin
				if (tick_q) begin
					prev_hi_q <= line_q;
					if (prev_hi_q && !line_q) begin
						state_q  <= UAR_START;
						samp_q   <= 5'h02;
						dbl_q    <= i_double_speed_select;
						par_en_q <= i_parity_en;
						nbits_q  <= clamp_bits(i_data_bits);
					end
				end
			end
			UAR_START: begin
				if (tick_q) begin
					samp_q <= samp_q + 5'h01;
					if (in_window) begin
						votes_q <= vset;
					end
					if (vote_end) begin
						if (bit_val) begin
							// noise spike: wait for a fresh high first
							state_q   <= UAR_IDLE;
							prev_hi_q <= line_q;
						end else begin
							state_q <= UAR_DATA;
							bit_q   <= 4'h0;
						end
					end
				end
			end
			UAR_DATA: begin
				if (tick_q) begin
					if (in_window) begin
						votes_q <= vset;
					end
					if (samp_q == spb(dbl_q)) begin
						samp_q <= 5'h01;
						bit_q  <= bit_q + 4'h1;
					end else begin
						samp_q <= samp_q + 5'h01;
					end
					if (vote_end && bit_q == last_bit) begin
						state_q   <= UAR_PUSH;
						prev_hi_q <= line_q;
					end
				end
			end
			UAR_PUSH: begin
				// a full fifo stalls here; edges are missed meanwhile
				if (fifo_ready) begin
					state_q <= UAR_IDLE;
				end
			end
			default: begin
				state_q <= UAR_IDLE;
			end
			endcase
		end
	end
	// ********************************
	// bit capture
	// ********************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			data_q <= 9'h000;
			par_q  <= 1'b0;
			fe_q   <= 1'b0;
		end else if (state_q == UAR_START) begin
			data_q <= 9'h000;
			par_q  <= 1'b0;
		end else if (state_q == UAR_DATA && vote_end && bit_q != 4'h0) begin
			if (bit_q <= nbits_q) begin
				data_q[bit_q - 4'h1] <= bit_val;
			end else if (bit_q == last_bit) begin
				fe_q <= !bit_val;
			end else begin
				par_q <= bit_val;
			end
		end
	end

	// ********************************
	// frame fifo
	// ********************************
	logic [`UAR_WORD_W-1:0] out_word;
	uar_fifo #(
		.WIDTH (`UAR_WORD_W),
		.DEPTH (`UAR_FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (state_q == UAR_PUSH),
		.i_in_data   (word),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_rx_valid),
		.o_out_data  (out_word),
		.i_out_ready (i_rx_ready)
	);
	assign o_rx_data          = out_word[8:0];
	assign o_rx_parity        = out_word[`UAR_PAR_POS];
	assign o_frame_error_flag = out_word[`UAR_FE_POS];

	// ********************************
	// assertions
	// ********************************
	sequence s_vote_end;
		vote_end;
	endsequence
	sequence s_start_noise;
		state_q == UAR_START ##0 s_vote_end ##0 bit_val;
	endsequence
	property p_noise_reject;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_start_noise |=> state_q == UAR_IDLE;
	endproperty
	a_noise_reject: assert property (p_noise_reject)
		else $error("noise start not rejected");
	property p_qual_point;
		@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == UAR_START && tick_q && samp_q != sf + 5'h02)
			|=> state_q == UAR_START;
	endproperty
	a_qual_point: assert property (p_qual_point)
		else $error("start decided off the vote sample");
	property p_resync;
		@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == UAR_START && vote_end && !bit_val)
			|=> state_q == UAR_DATA && bit_q == 4'h0
			&& samp_q == sf + 5'h03;
	endproperty
	a_resync: assert property (p_resync)
		else $error("no resync on valid start");
	property p_spb_limit;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_q == UAR_DATA |-> samp_q >= 5'h01 && samp_q <= spb(dbl_q);
	endproperty
	a_spb_limit: assert property (p_spb_limit)
		else $error("sample state out of range");
	property p_dbl_mode;
		@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == UAR_IDLE && tick_q && prev_hi_q && !line_q)
			|=> dbl_q == $past(i_double_speed_select);
	endproperty
	a_dbl_mode: assert property (p_dbl_mode)
		else $error("speed mode not taken at start");
	property p_stop_end;
		@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == UAR_DATA && vote_end && bit_q == last_bit)
			|=> state_q == UAR_PUSH && fe_q == !$past(bit_val);
	endproperty
	a_stop_end: assert property (p_stop_end)
		else $error("stop bit handling wrong");
	property p_sync;
		@(posedge i_clk) disable iff (!i_reset_n)
		$changed(line_q) |-> $past(sync2_q) == $past(sync3_q);
	endproperty
	a_sync: assert property (p_sync)
		else $error("line changed without agreement");
	property p_rearm;
		@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == UAR_PUSH && fifo_ready) |=> state_q == UAR_IDLE
			##1 (state_q == UAR_IDLE || state_q == UAR_START);
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("receiver not re-armed after stop");
endmodule : uar_rx

// file: sim/uar_tx_model.sv
// partner model: remote asynchronous transmitter driving the serial line
`timescale 1ns/100ps
module uar_tx_model (
	input  wire logic i_clk,
	output logic      o_line
);
	// line idles high between frames
	initial o_line = 1'b1;

	task automatic hold(input logic v, input int n);
		o_line = v;
		repeat (n) @(negedge i_clk);
	endtask : hold

	// exact bit rate, well inside the tolerated ratio; stop left on line
	task automatic send(input logic [8:0] d, input int nb, input logic pe,
		input logic par, input logic stp, input int cpb, input int stop_n);
		hold(1'b0, cpb);
		for (int i = 0; i < nb; i++) begin
			hold(d[i], cpb);
		end
		if (pe) begin
			hold(par, cpb);
		end
		hold(stp, stop_n);
	endtask : send
endmodule : uar_tx_model

// file: sim/testbench.sv
// self-checking bench for the asynchronous receive recovery block
`timescale 1ns/100ps
`include "uar_regs.svh"
module testbench;
	logic                  i_clk;
	logic                  i_reset_n;
	logic                  ds;
	logic                  pen;
	logic                  rdy;
	logic [`UAR_DIV_W-1:0] div;
	logic [3:0]            nb;
	logic                  line;
	logic                  vld;
	logic                  par;
	logic                  fe;
	logic [8:0]            dat;
	int                    n_errors;
	int                    n_tests;

	uar_rx dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial_rx_line(line),
		.i_double_speed_select(ds), .i_baud_divisor(div), .i_data_bits(nb),
		.i_parity_en(pen), .i_rx_ready(rdy), .o_rx_valid(vld),
		.o_rx_data(dat), .o_rx_parity(par), .o_frame_error_flag(fe));
	uar_tx_model tx (.i_clk(i_clk), .o_line(line));

	initial i_clk = 1'b0;
	always #(`UAR_CLK_PERIOD_NS / 2) i_clk = ~i_clk;

	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	task automatic fail(input string m);
		n_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask : fail

	task automatic cfg(input logic d, input int dv, input int b, input logic p);
		ds = d;
		div = dv[`UAR_DIV_W-1:0];
		nb = b[3:0];
		pen = p;
	endtask : cfg

	// wait for a word, compare it, then take it with a one-edge ready
	task automatic take(input logic [8:0] d, input logic p, input logic f);
		int k;
		k = 0;
		while (vld !== 1'b1 && k < 600) begin
			@(negedge i_clk);
			k++;
		end
		n_tests++;
		if (vld !== 1'b1) begin
			fail("no word");
			end_of_test();
		end
		n_tests++;
		if ({dat, par, fe} !== {d, p, f}) begin
			fail($sformatf("word %h exp %h", {dat, par, fe}, {d, p, f}));
		end
		rdy = 1'b1;
		@(negedge i_clk);
		rdy = 1'b0;
		// one idle edge so a following take never re-raises ready at once
		@(negedge i_clk);
	endtask : take

	//****************************************
	// scenarios
	//****************************************
	task automatic t_normal;
		cfg(1'b0, 0, 8, 1'b1);
		tx.send(9'h0A5, 8, 1'b1, 1'b1, 1'b1, 16, 16);
		take(9'h0A5, 1'b1, 1'b0);
		cfg(1'b0, 1, 5, 1'b0);
		tx.send(9'h1F5, 5, 1'b0, 1'b0, 1'b1, 32, 32);
		take(9'h015, 1'b0, 1'b0);
		// frame sizes outside five to nine fall back to the nearest limit
		cfg(1'b0, 0, 4, 1'b0);
		tx.send(9'h1EA, 5, 1'b0, 1'b0, 1'b1, 16, 16);
		take(9'h00A, 1'b0, 1'b0);
		cfg(1'b0, 0, 15, 1'b1);
		tx.send(9'h155, 9, 1'b1, 1'b0, 1'b1, 16, 16);
		take(9'h155, 1'b0, 1'b0);
	endtask : t_normal

	task automatic t_double;
		// divisor 3 gives 32 clocks per bit at 8 samples per bit
		cfg(1'b1, 3, 9, 1'b1);
		tx.send(9'h1C3, 9, 1'b1, 1'b0, 1'b1, 32, 32);
		take(9'h1C3, 1'b0, 1'b0);
	endtask : t_double

	task automatic t_frame;
		cfg(1'b0, 0, 8, 1'b0);
		tx.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 16, 16);
		tx.hold(1'b1, 16);
		// short stop: next start right after the last stop vote
		tx.send(9'h0C3, 8, 1'b0, 1'b0, 1'b1, 16, 12);
		tx.send(9'h055, 8, 1'b0, 1'b0, 1'b1, 16, 32);
		take(9'h03C, 1'b0, 1'b1);
		take(9'h0C3, 1'b0, 1'b0);
		take(9'h055, 1'b0, 1'b0);
	endtask : t_frame

	task automatic t_glitch;
		cfg(1'b0, 0, 8, 1'b0);
		tx.hold(1'b0, 5);
		tx.hold(1'b1, 40);
		tx.send(9'h081, 8, 1'b0, 1'b0, 1'b1, 16, 16);
		take(9'h081, 1'b0, 1'b0);
		n_tests++;
		if (vld !== 1'b0) fail("spike gave a word");
	endtask : t_glitch

	task automatic t_fifo;
		logic [7:0] v;
		// seventeen words fill the fifo and its output stage; the
		// eighteenth must wait in the receiver until room opens
		cfg(1'b0, 0, 8, 1'b1);
		for (int i = 0; i < 18; i++) begin
			v = 8'h5A ^ i[7:0];
			tx.send({1'b0, v}, 8, 1'b1, ^v, 1'b1, 16, 16);
		end
		for (int i = 0; i < 18; i++) begin
			v = 8'h5A ^ i[7:0];
			take({1'b0, v}, ^v, 1'b0);
		end
		n_tests++;
		if (vld !== 1'b0) fail("extra word after drain");
	endtask : t_fifo

	initial begin
		i_reset_n = 1'b0;
		rdy = 1'b0;
		cfg(1'b0, 0, 8, 1'b0);
		n_errors = 0;
		n_tests = 0;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (4) @(negedge i_clk);
		t_normal();
		t_double();
		t_frame();
		t_glitch();
		t_fifo();
		end_of_test();
	end
endmodule : testbench
